/* File: smu_pkg.sv */
// Shared constants and types for the saturating magnitude unit
package smu_pkg;

  // Register byte offsets
  localparam logic [7:0] SMU_OFF_SRC = 8'h00;
  localparam logic [7:0] SMU_OFF_LIMM = 8'h04;
  localparam logic [7:0] SMU_OFF_CTRL = 8'h08;
  localparam logic [7:0] SMU_OFF_RESULT = 8'h0c;
  localparam logic [7:0] SMU_OFF_FLAGS = 8'h10;

  // Command register fields
  localparam int SMU_CTRL_W = 14;
  localparam int SMU_CTRL_OP_LSB = 0;
  localparam int SMU_CTRL_SETF_BIT = 2;
  localparam int SMU_CTRL_NORES_BIT = 3;
  localparam int SMU_CTRL_KIND_LSB = 4;
  localparam int SMU_CTRL_IMM_LSB = 8;
  localparam int SMU_IMM_W = 6;

  // Status flag positions
  localparam int SMU_FLG_W = 7;
  localparam int SMU_FLG_Z = 0;
  localparam int SMU_FLG_N = 1;
  localparam int SMU_FLG_C = 2;
  localparam int SMU_FLG_V = 3;
  localparam int SMU_FLG_S = 4;
  localparam int SMU_FLG_SAT_ONE = 5;
  localparam int SMU_FLG_SAT_TWO = 6;

  // Reset values
  localparam logic [SMU_FLG_W-1:0] SMU_FLAGS_RST = 7'h00;
  localparam logic [SMU_CTRL_W-1:0] SMU_CTRL_RST = 14'h0003;
  localparam logic [31:0] SMU_WORD_RST = 32'h0000_0000;

  // Arithmetic limits
  localparam logic [31:0] SMU_MIN32 = 32'h8000_0000;
  localparam logic [31:0] SMU_MAX32 = 32'h7fff_ffff;
  localparam logic [15:0] SMU_MIN16 = 16'h8000;
  localparam logic [15:0] SMU_MAX16 = 16'h7fff;

  typedef enum logic [1:0] {
    SMU_OP_PLAIN, SMU_OP_SAT32, SMU_OP_SATHW, SMU_OP_NONE
  } smu_op_e;

  typedef enum logic [1:0] {
    SMU_SRC_REG, SMU_SRC_IMM6, SMU_SRC_LIMM, SMU_SRC_NONE
  } smu_kind_e;

endpackage

/* File: smu_mag_core.sv */
// Combinational magnitude datapath with flag candidates
`timescale 1ns/1ps
`default_nettype none
module smu_mag_core
  import smu_pkg::*;
(
  input wire smu_op_e op, // Operation select
  input wire logic [31:0] src, // Source operand
  output logic [31:0] result, // Magnitude result
  output logic sat, // Saturation event
  output logic z, // Zero flag candidate
  output logic n, // Negative flag candidate
  output logic c, // Carry flag candidate
  output logic c_upd, // Carry is to be loaded
  output logic v // Overflow flag candidate
);

  logic [31:0] neg32;
  logic [15:0] low_halfword;
  logic [15:0] neg16;

  always_comb begin
    neg32 = 32'h0000_0000 - src;
    low_halfword = src[15:0];
    neg16 = 16'h0000 - low_halfword;
    result = src;
    sat = 1'b0;
    z = (src == 32'h0000_0000); // see RL8
    n = src[31]; // see RL8
    c = src[31];
    c_upd = 1'b0; // see RL8
    v = 1'b0;
    case (op)
      SMU_OP_PLAIN: begin
        result = src[31] ? neg32 : src; // see RL1
        z = (result == 32'h0000_0000); // see RL3
        c_upd = 1'b1; // see RL4
        n = (src == SMU_MIN32); // see RL5
        v = (src == SMU_MIN32); // see RL5
      end
      SMU_OP_SAT32: begin
        if (src == SMU_MIN32) begin
          result = SMU_MAX32; // see RL7
          sat = 1'b1;
        end else if (src[31]) begin
          result = neg32; // see RL6
        end
        v = sat; // see RL9
      end
      SMU_OP_SATHW: begin
        // Upper halfword never reaches the result
        if (low_halfword == SMU_MIN16) begin
          result = {16'h0000, SMU_MAX16}; // see RL12
          sat = 1'b1; // see RL13
        end else if (low_halfword[15]) begin
          result = {16'h0000, neg16}; // see RL11
        end else begin
          result = {16'h0000, low_halfword}; // see RL11
        end
        v = sat; // see RL13
      end
      default: begin
        result = src;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: smu_top.sv */
// AHB-Lite front end, operand select and flag state of the unit
`timescale 1ns/1ps
`default_nettype none
// Contract
// RL1: Plain op writes zero minus source if bit 31 is set, else source.
// RL2: No flag changes in any of the three ops without set-flags.
// RL3: Plain with set-flags sets zero exactly when the result is zero.
// RL4: Plain with set-flags loads carry with bit 31 of the original source.
// RL5: Plain with set-flags sets N and V only for source 0x8000_0000.
// RL6: Saturating 32-bit op passes non-negative sources, negates others.
// RL7: Saturating 32-bit turns 0x8000_0000 into 0x7FFF_FFFF and saturates.
// RL8: Saturating 32-bit takes Z and N from the input, keeps carry.
// RL9: Saturating ops set overflow on saturation, else clear, and OR sticky.
// RL10: A saturating result sets both extended saturation flags together.
// RL11: Halfword op takes the magnitude of the low 16 bits only.
// RL12: Halfword op turns low half 0x8000 into 0x0000_7FFF.
// RL13: Halfword op sets V and sticky on 0x8000, else clears V, keeps carry.
// RL14: Forms without a result update flags alike but write no register.
// RL15: Register, zero-extended six-bit and long immediates act alike.
module smu_top
  import smu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic hclk, // Core clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic hsel, // Slave select
  input wire logic [ADDR_W-1:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic hready, // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] result_data, // Destination register value
  output logic result_we, // Destination write strobe
  output logic flag_zero, // Zero flag
  output logic flag_negative, // Negative flag
  output logic flag_carry, // Carry flag
  output logic flag_overflow, // Overflow flag
  output logic flag_sticky_sat, // Sticky saturation flag
  output logic saturation_flag_one, // Extended saturation flag one
  output logic saturation_flag_two // Extended saturation flag two
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    logic [ADDR_W-1:0] o;
    o = ADDR_W'(off);
    return a[ADDR_W-1:2] == o[ADDR_W-1:2];
  endfunction

  // Bus state
  logic wr_pend_q, wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hresp_q;
  // Block state
  logic [31:0] src_q, src_d;
  logic [31:0] limm_q, limm_d;
  logic [SMU_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [31:0] result_q, result_d;
  logic result_we_q, result_we_d;
  logic [SMU_FLG_W-1:0] flags_q, flags_d;

  // Command decode from the write data of a command write
  logic accept;
  logic ctrl_wr;
  logic exec;
  smu_op_e cmd_op;
  smu_kind_e cmd_kind;
  logic cmd_setf;
  logic cmd_nores;
  logic [SMU_IMM_W-1:0] six_bit_unsigned_immediate;
  logic [31:0] operand;
  logic [31:0] core_res;
  logic core_sat, core_z, core_n, core_c, core_cupd, core_v;

  assign accept = hready && hsel && htrans[1];
  assign ctrl_wr = wr_pend_q && reg_hit(wr_addr_q, SMU_OFF_CTRL);
  assign cmd_op = smu_op_e'(hwdata[SMU_CTRL_OP_LSB +: 2]);
  assign cmd_kind = smu_kind_e'(hwdata[SMU_CTRL_KIND_LSB +: 2]);
  assign cmd_setf = hwdata[SMU_CTRL_SETF_BIT];
  assign cmd_nores = hwdata[SMU_CTRL_NORES_BIT];
  assign six_bit_unsigned_immediate =
    hwdata[SMU_CTRL_IMM_LSB +: SMU_IMM_W];
  // A reserved op code is stored but does nothing
  assign exec = ctrl_wr && (cmd_op != SMU_OP_NONE);

  always_comb begin
    case (cmd_kind)
      SMU_SRC_IMM6: operand =
        {26'h0, six_bit_unsigned_immediate}; // see RL15
      SMU_SRC_LIMM: operand = limm_q; // see RL15
      default: operand = src_q; // see RL15
    endcase
  end

  smu_mag_core u_core (
    .op(cmd_op),
    .src(operand),
    .result(core_res),
    .sat(core_sat),
    .z(core_z),
    .n(core_n),
    .c(core_c),
    .c_upd(core_cupd),
    .v(core_v)
  );

  always_comb begin
    wr_pend_d = accept && hwrite;
    wr_addr_d = accept ? haddr : wr_addr_q;
    src_d = src_q;
    limm_d = limm_q;
    ctrl_d = ctrl_q;
    result_d = result_q;
    result_we_d = 1'b0;
    flags_d = flags_q;
    if (wr_pend_q) begin
      if (reg_hit(wr_addr_q, SMU_OFF_SRC)) begin
        src_d = hwdata;
      end
      if (reg_hit(wr_addr_q, SMU_OFF_LIMM)) begin
        limm_d = hwdata;
      end
      if (ctrl_wr) begin
        ctrl_d = hwdata[SMU_CTRL_W-1:0];
      end
      if (reg_hit(wr_addr_q, SMU_OFF_FLAGS)) begin
        flags_d = hwdata[SMU_FLG_W-1:0];
      end
    end
    if (exec) begin
      if (!cmd_nores) begin
        result_d = core_res; // see RL14
        result_we_d = 1'b1;
      end
      if (cmd_setf) begin // see RL2
        flags_d[SMU_FLG_Z] = core_z;
        flags_d[SMU_FLG_N] = core_n;
        if (core_cupd) begin
          flags_d[SMU_FLG_C] = core_c; // see RL4
        end
        flags_d[SMU_FLG_V] = core_v; // see RL9
        // Sticky bits are set by an operation here or by a write to the flags register
        if (core_sat) begin
          flags_d[SMU_FLG_S] = 1'b1; // see RL9
          flags_d[SMU_FLG_SAT_ONE] = 1'b1; // see RL10
          flags_d[SMU_FLG_SAT_TWO] = 1'b1; // see RL10
        end
      end
    end
    // Read mux looks at next values so a read right behind a write
    // returns the freshly written state without a wait state
    hrdata_d = hrdata_q;
    if (accept && !hwrite) begin
      hrdata_d = 32'h0000_0000;
      if (reg_hit(haddr, SMU_OFF_SRC)) begin
        hrdata_d = src_d;
      end
      if (reg_hit(haddr, SMU_OFF_LIMM)) begin
        hrdata_d = limm_d;
      end
      if (reg_hit(haddr, SMU_OFF_CTRL)) begin
        hrdata_d = {{(32-SMU_CTRL_W){1'b0}}, ctrl_d};
      end
      if (reg_hit(haddr, SMU_OFF_RESULT)) begin
        hrdata_d = result_d;
      end
      if (reg_hit(haddr, SMU_OFF_FLAGS)) begin
        hrdata_d = {{(32-SMU_FLG_W){1'b0}}, flags_d};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= SMU_WORD_RST;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      src_q <= SMU_WORD_RST;
      limm_q <= SMU_WORD_RST;
      ctrl_q <= SMU_CTRL_RST;
      result_q <= SMU_WORD_RST;
      result_we_q <= 1'b0;
      flags_q <= SMU_FLAGS_RST;
    end else if (clk_en) begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      src_q <= src_d;
      limm_q <= limm_d;
      ctrl_q <= ctrl_d;
      result_q <= result_d;
      result_we_q <= result_we_d;
      flags_q <= flags_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign result_data = result_q;
  assign result_we = result_we_q;
  assign flag_zero = flags_q[SMU_FLG_Z];
  assign flag_negative = flags_q[SMU_FLG_N];
  assign flag_carry = flags_q[SMU_FLG_C];
  assign flag_overflow = flags_q[SMU_FLG_V];
  assign flag_sticky_sat = flags_q[SMU_FLG_S];
  assign saturation_flag_one = flags_q[SMU_FLG_SAT_ONE];
  assign saturation_flag_two = flags_q[SMU_FLG_SAT_TWO];

  // Checking helpers: remember the command that just executed
  logic chk_q, chk_d;
  smu_op_e chk_op_q, chk_op_d;
  logic [31:0] chk_src_q, chk_src_d;
  logic chk_setf_q, chk_setf_d;
  logic chk_nores_q, chk_nores_d;
  logic chk_imm6_q, chk_imm6_d;
  logic [SMU_IMM_W-1:0] chk_imm_q, chk_imm_d;
  logic [SMU_FLG_W-1:0] chk_flags_q, chk_flags_d;
  logic [31:0] chk_res_q, chk_res_d;
  logic chk_sat;

  always_comb begin
    chk_d = exec;
    chk_op_d = exec ? cmd_op : chk_op_q;
    chk_src_d = exec ? operand : chk_src_q;
    chk_setf_d = exec ? cmd_setf : chk_setf_q;
    chk_nores_d = exec ? cmd_nores : chk_nores_q;
    chk_imm6_d = exec ? (cmd_kind == SMU_SRC_IMM6) : chk_imm6_q;
    chk_imm_d = exec ? six_bit_unsigned_immediate : chk_imm_q;
    chk_flags_d = exec ? flags_q : chk_flags_q;
    chk_res_d = exec ? result_q : chk_res_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chk_q <= 1'b0;
      chk_op_q <= SMU_OP_NONE;
      chk_src_q <= SMU_WORD_RST;
      chk_setf_q <= 1'b0;
      chk_nores_q <= 1'b0;
      chk_imm6_q <= 1'b0;
      chk_imm_q <= '0;
      chk_flags_q <= SMU_FLAGS_RST;
      chk_res_q <= SMU_WORD_RST;
    end else if (clk_en) begin
      chk_q <= chk_d;
      chk_op_q <= chk_op_d;
      chk_src_q <= chk_src_d;
      chk_setf_q <= chk_setf_d;
      chk_nores_q <= chk_nores_d;
      chk_imm6_q <= chk_imm6_d;
      chk_imm_q <= chk_imm_d;
      chk_flags_q <= chk_flags_d;
      chk_res_q <= chk_res_d;
    end
  end

  assign chk_sat = (chk_op_q == SMU_OP_SAT32) ?
    (chk_src_q == SMU_MIN32) : (chk_src_q[15:0] == SMU_MIN16);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PLAIN_RES: assert property ( // see RL1
    chk_q && chk_op_q == SMU_OP_PLAIN && !chk_nores_q |->
    result_q == (chk_src_q[31] ? 32'h0 - chk_src_q : chk_src_q))
    else $error("plain magnitude result wrong");
  AST_NOFLAG_HOLD: assert property ( // see RL2
    chk_q && !chk_setf_q |-> flags_q == chk_flags_q)
    else $error("flags changed without set-flags");
  AST_PLAIN_Z: assert property ( // see RL3
    chk_q && chk_setf_q && chk_op_q == SMU_OP_PLAIN |->
    flags_q[SMU_FLG_Z] == (chk_src_q == 32'h0))
    else $error("plain zero flag wrong");
  AST_PLAIN_C: assert property ( // see RL4
    chk_q && chk_setf_q && chk_op_q == SMU_OP_PLAIN |->
    flags_q[SMU_FLG_C] == chk_src_q[31])
    else $error("plain carry flag wrong");
  AST_PLAIN_NV: assert property ( // see RL5
    chk_q && chk_setf_q && chk_op_q == SMU_OP_PLAIN |->
    flags_q[SMU_FLG_N] == (chk_src_q == SMU_MIN32) &&
    flags_q[SMU_FLG_V] == (chk_src_q == SMU_MIN32))
    else $error("plain negative or overflow wrong");
  AST_SAT32_RES: assert property ( // see RL6
    chk_q && chk_op_q == SMU_OP_SAT32 && !chk_nores_q &&
    chk_src_q != SMU_MIN32 |->
    result_q == (chk_src_q[31] ? 32'h0 - chk_src_q : chk_src_q))
    else $error("saturating magnitude result wrong");
  AST_SAT32_MIN: assert property ( // see RL7
    chk_q && chk_op_q == SMU_OP_SAT32 && !chk_nores_q &&
    chk_src_q == SMU_MIN32 |-> result_q == SMU_MAX32)
    else $error("saturating result not clamped");
  AST_SAT_ZNC: assert property ( // see RL8
    chk_q && chk_setf_q && chk_op_q != SMU_OP_PLAIN |->
    flags_q[SMU_FLG_Z] == (chk_src_q == 32'h0) &&
    flags_q[SMU_FLG_N] == chk_src_q[31] &&
    flags_q[SMU_FLG_C] == chk_flags_q[SMU_FLG_C])
    else $error("saturating zero, negative or carry wrong");
  AST_SAT_VS: assert property ( // see RL9
    chk_q && chk_setf_q && chk_op_q != SMU_OP_PLAIN |->
    flags_q[SMU_FLG_V] == chk_sat &&
    flags_q[SMU_FLG_S] == (chk_flags_q[SMU_FLG_S] | chk_sat))
    else $error("overflow or sticky flag wrong");
  AST_SAT_BOTH: assert property ( // see RL10
    chk_q && chk_setf_q && chk_op_q != SMU_OP_PLAIN && chk_sat |->
    flags_q[SMU_FLG_SAT_ONE] && flags_q[SMU_FLG_SAT_TWO])
    else $error("saturation flags not both set");
  AST_HW_HIGH: assert property ( // see RL11
    chk_q && chk_op_q == SMU_OP_SATHW && !chk_nores_q |->
    result_q[31:16] == 16'h0000 && (chk_sat ||
    result_q[15:0] == (chk_src_q[15] ?
    16'h0 - chk_src_q[15:0] : chk_src_q[15:0])))
    else $error("halfword magnitude wrong");
  AST_HW_SAT: assert property ( // see RL12
    chk_q && chk_op_q == SMU_OP_SATHW && !chk_nores_q && chk_sat |->
    result_q == {16'h0000, SMU_MAX16})
    else $error("halfword result not clamped");
  AST_HW_V: assert property ( // see RL13
    chk_q && chk_setf_q && chk_op_q == SMU_OP_SATHW |->
    flags_q[SMU_FLG_V] == (chk_src_q[15:0] == SMU_MIN16))
    else $error("halfword overflow wrong");
  AST_NORES: assert property ( // see RL14
    chk_q && chk_nores_q |-> result_q == chk_res_q && !result_we_q)
    else $error("no-result form wrote a result");
  AST_IMM6: assert property ( // see RL15
    chk_q && chk_imm6_q && !chk_nores_q |->
    result_q == {26'h0, chk_imm_q})
    else $error("six-bit immediate operand wrong");

  COV_PLAIN_MIN: cover property (
    chk_q && chk_op_q == SMU_OP_PLAIN && chk_src_q == SMU_MIN32);
  COV_SAT32: cover property (
    chk_q && chk_setf_q && chk_op_q == SMU_OP_SAT32 && chk_sat);
  COV_SATHW: cover property (
    chk_q && chk_setf_q && chk_op_q == SMU_OP_SATHW && chk_sat);
  COV_NORES: cover property (chk_q && chk_nores_q && chk_setf_q);

endmodule
`default_nettype wire

/* File: smu_bus_master.sv */
// Bus master model standing in for the issuing pipeline
`timescale 1ns/1ps
`default_nettype none
module smu_bus_master (
  input wire logic hclk, // Core clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output var logic hsel, // Slave select
  output var logic [7:0] haddr, // Byte address
  output var logic [1:0] htrans, // Transfer type
  output var logic hwrite, // Write when high
  output var logic [2:0] hsize, // Transfer size
  output var logic [31:0] hwdata // Write data
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Gap cycles let the pipeline issue slowly; even with no gap a transfer starts only every third cycle;
  // released lines show inverted junk so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input int gap, output logic [31:0] r);
    repeat (gap) @(posedge hclk);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

/* File: test_saturating_magnitude_unit.sv */
// Self-checking bench for the saturating magnitude unit
`timescale 1ns/1ps
`default_nettype none
module test_saturating_magnitude_unit
  import smu_pkg::*;
;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp, result_we;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, result_data, seed, res_q, rd;
  wire logic [6:0] flg;
  int n_fail, checked;
  localparam logic [31:0] CORNER [0:8] = '{32'h0000_0000, 32'h0000_0001,
    32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff, 32'hffff_8000,
    32'h0000_8000, 32'h8001_7fff, 32'h1234_0000};

  smu_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .result_data(result_data),
    .result_we(result_we), .flag_zero(flg[0]), .flag_negative(flg[1]),
    .flag_carry(flg[2]), .flag_overflow(flg[3]),
    .flag_sticky_sat(flg[4]), .saturation_flag_one(flg[5]),
    .saturation_flag_two(flg[6]));

  smu_bus_master pipe (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Reset values, an unmapped place and the read-only result register
  task automatic check_reset();
    #1;
    chk(result_data, SMU_WORD_RST);
    chk({25'h0, flg}, {25'h0, SMU_FLAGS_RST});
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    pipe.xfer(1'b0, SMU_OFF_CTRL, 32'h0, 0, rd);
    chk(rd, {18'h0, SMU_CTRL_RST});
    pipe.xfer(1'b1, 8'h14, rnd(), 0, rd);
    pipe.xfer(1'b0, 8'h14, 32'h0, 0, rd);
    chk(rd, 32'h0);
    pipe.xfer(1'b1, SMU_OFF_RESULT, rnd(), 0, rd);
    pipe.xfer(1'b0, SMU_OFF_RESULT, 32'h0, 0, rd);
    chk(rd, res_q);
  endtask

  // Flags are preloaded at random so kept and sticky bits are exercised
  task automatic run_op(input logic [1:0] op, input logic sf,
    input logic nr, input logic [1:0] kd, input logic [31:0] v);
    logic [31:0] s, r, t;
    logic [6:0] f;
    logic sat;
    t = rnd();
    f = t[6:0];
    pipe.xfer(1'b1, SMU_OFF_FLAGS, {25'h0, f}, t[8], rd);
    pipe.xfer(1'b1, SMU_OFF_SRC, kd == 2'd2 ? ~v : v, t[9], rd);
    pipe.xfer(1'b1, SMU_OFF_LIMM, kd == 2'd2 ? v : ~v, 0, rd);
    s = kd == 2'd1 ? {26'h0, v[5:0]} : v;
    sat = 1'b0;
    r = s[31] ? 32'h0 - s : s;
    if (op == 2'd1 && s == SMU_MIN32) begin
      r = SMU_MAX32;
      sat = 1'b1;
    end
    if (op == 2'd2) begin
      r = s[15] ? {16'h0, 16'h0 - s[15:0]} : {16'h0, s[15:0]};
      sat = s[15:0] == SMU_MIN16;
      if (sat) r = {16'h0, SMU_MAX16};
    end
    if (sf && op == 2'd0) begin
      f[SMU_FLG_Z] = r == 32'h0;
      f[SMU_FLG_N] = s == SMU_MIN32;
      f[SMU_FLG_C] = s[31];
      f[SMU_FLG_V] = s == SMU_MIN32;
    end
    if (sf && (op == 2'd1 || op == 2'd2)) begin
      f[SMU_FLG_Z] = s == 32'h0;
      f[SMU_FLG_N] = s[31];
      f[SMU_FLG_V] = sat;
      f[SMU_FLG_S] |= sat;
      f[SMU_FLG_SAT_ONE] |= sat;
      f[SMU_FLG_SAT_TWO] |= sat;
    end
    if (op != 2'd3 && !nr) res_q = r;
    pipe.xfer(1'b1, SMU_OFF_CTRL, {18'h0, v[5:0], 2'b00, kd, nr, sf, op},
      t[10], rd);
    #1;
    chk({31'h0, result_we}, {31'h0, op != 2'd3 && !nr});
    chk(result_data, res_q);
    chk({25'h0, flg}, {25'h0, f});
    pipe.xfer(1'b0, SMU_OFF_RESULT, 32'h0, 0, rd);
    chk(rd, res_q);
  endtask

  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    n_fail = 0;
    checked = 0;
    seed = 32'h0000_64da;
    res_q = 32'h0000_0000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    check_reset();
    for (int c = 0; c < 64; c++) begin
      for (int i = 0; i < 12; i++) begin
        run_op(c[1:0], c[2], c[3], c[5:4], i < 9 ? CORNER[i] : rnd());
      end
    end
    // A write issued while the clock enable is low must be lost
    pipe.xfer(1'b1, SMU_OFF_SRC, 32'h1234_5678, 0, rd);
    clk_en <= 1'b0;
    pipe.xfer(1'b1, SMU_OFF_SRC, 32'h0000_00ff, 0, rd);
    clk_en <= 1'b1;
    pipe.xfer(1'b0, SMU_OFF_SRC, 32'h0, 0, rd);
    chk(rd, 32'h1234_5678);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    res_q = 32'h0000_0000;
    check_reset();
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
